// ### ovq_consts.svh
// Constants for the overlap and queue control block
`ifndef OVQ_CONSTS_SVH
`define OVQ_CONSTS_SVH
// Host port register addresses
`define OVQ_A_DATA 4'h0
`define OVQ_A_ERRFEAT 4'h1
`define OVQ_A_SCNT 4'h2
`define OVQ_A_SNUM 4'h3
`define OVQ_A_CYLL 4'h4
`define OVQ_A_CYLH 4'h5
`define OVQ_A_HEAD 4'h6
`define OVQ_A_STATCMD 4'h7
`define OVQ_A_ALTCTL 4'h8
`define OVQ_A_ID71 4'h9
// Command codes
`define OVQ_CMD_SETF 8'hef
`define OVQ_CMD_PIO_RD 8'h20
`define OVQ_CMD_PIO_WR 8'h30
`define OVQ_CMD_DMA_RD 8'hc8
`define OVQ_CMD_DMA_WR 8'hca
// Set-features subcommands
`define OVQ_SF_OVL_NOSEL 8'hdd
`define OVQ_SF_OVL_SEL 8'hde
`define OVQ_SF_OVL_OFF 8'hdf
// Field positions
`define OVQ_FEAT_OVL 7
`define OVQ_HEAD_UNIT 4
`define OVQ_CTL_NIEN 1
`define OVQ_ERR_ABRT 2
`define OVQ_ID_OVL 15
`define OVQ_ID_QD_LSB 11
// Advertised depth field: depth is field plus one, never above eight
`define OVQ_QDEPTH_FIELD 4'h3
`define OVQ_CTX_DEPTH 8
// Words moved per data request block
`define OVQ_BLOCK_WORDS 9'd256
// Reset values
`define OVQ_HEAD_RST 8'h00
`define OVQ_STRAP_WAIT 2'd3
`endif

// ### ovq_pkg.sv
// Types for the overlap and queue control block
package ovq_pkg;
  typedef enum logic [1:0] {OVQ_K_NONDATA, OVQ_K_PIO, OVQ_K_DMA, OVQ_K_SETF} ovq_kind_t;
  typedef enum logic [1:0] {OVQ_S_IDLE, OVQ_S_SAVE, OVQ_S_EXEC} ovq_state_t;
endpackage : ovq_pkg

// ### ovq_ctx_store.sv
// Saved command context store, one entry per queue tag
`include "ovq_consts.svh"
module ovq_ctx_store
  import ovq_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Save side
  input wire logic wr_en,
  input wire logic [2:0] wr_tag,
  input wire logic [47:0] wr_word,
  // Release side
  input wire logic clr_en,
  input wire logic [2:0] clr_tag,
  input wire logic clr_all,
  // Lookup side
  input wire logic [2:0] rd_tag,
  output logic [47:0] rd_word,
  output logic [7:0] valid_mask
);
  logic [47:0] mem_q [0:`OVQ_CTX_DEPTH-1];
  logic [7:0] valid_q;
  logic [7:0] valid_d;
  logic [47:0] rd_q;
  wire [7:0] set_mask = wr_en ? (8'h01 << wr_tag) : 8'h00;
  wire [7:0] clr_mask = clr_all ? 8'hff : (clr_en ? (8'h01 << clr_tag) : 8'h00);

  // A save landing with a release keeps the entry alive
  assign valid_d = (valid_q & ~clr_mask) | set_mask;
  assign valid_mask = valid_q;
  assign rd_word = rd_q;

  // Storage needs no reset; the valid bits guard it
  always_ff @(posedge ref_clk)
  begin
    if (wr_en)
      mem_q[wr_tag] <= wr_word;
    rd_q <= mem_q[rd_tag];
  end

  // Entry valid flags
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      valid_q <= 8'h00;
    else
      valid_q <= valid_d;
  end
endmodule : ovq_ctx_store

// ### ovq_ctrl.sv
// Device-side overlap, queue and interrupt control behind the host register port
//
// The placing of the registers and the strobed register port were left to the implementer.
`include "ovq_consts.svh"
// Functional notes
// [RULE_01] Overlapped data command: set busy, lock registers, save context, clear busy.
// [RULE_02] Non-data command keeps busy set until execution finishes.
// [RULE_03] Queuing device takes a new command as soon as busy clears.
// [RULE_04] Mixed pair: host leaves the legacy unit alone until its command ends.
// [RULE_05] Host moves the select line only when no access or transfer runs.
// [RULE_06] Register writes refused while busy and accepted only while selected. Code: ctl_wr ignores busy; head writes pass unselected if select line off.
// [RULE_07] Unit 0 interrupts on primary line, unit 1 on second line, always. Code: only in overlap mode; legacy drives the primary line when selected.
// [RULE_08] Overlap unit strapped as unit 0 beside legacy unit 1 runs legacy.
// [RULE_09] Host leaves overlap mode on all units before running diagnostics.
// [RULE_10] Identification word 71 bit 15 reports overlap support.
// [RULE_11] Bits 14-11 give depth field; zero means no queue, else field plus one.
// [RULE_12] A tag above the advertised depth field aborts the command.
// [RULE_13] Host marks overlap and tag in features for each data command.
// [RULE_14] Tag of the serviced command shows in head bits 7, 5 and 4.
// [RULE_15] Different kind or non-data command while queued aborts the whole queue.
// [RULE_16] Subcommands DDh, DEh, DFh: overlap without select, with select, off.
// [RULE_17] Mixed data-in: host idles unit 0, selects unit 1, loads and commands.
// [RULE_18] Host polls busy low on unit 1 before selecting unit 0 again.
// [RULE_19] Data ready: set data request then interrupt; error: set complete then interrupt.
// [RULE_20] Status read drops the interrupt; alternate status read does not.
// [RULE_21] Data request clears once the block has been read out.
// [RULE_22] Final status: set command-complete first, then interrupt.
// [RULE_23] Status read during reporting clears complete, drops interrupt, ends command.
// [RULE_24] Host reads error when flagged and head for the tag before status.
// [RULE_25] Features bit 7 asks overlap, bits 6-3 reserved, bits 2-0 tag.
// [RULE_26] Index bit is command-complete in overlap mode, cleared by status read.
// [RULE_27] Select line asserted picks unit 0, negated picks unit 1.
// [RULE_28] Unselected with select line on: ignore bus, still raise interrupt.
// [RULE_29] Hold saved context per outstanding queued command up to the depth.
// [RULE_30] Depth lives in bits 14-11 and never exceeds eight entries.
module ovq_ctrl
  import ovq_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Host register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Activity or select pin, open collector, low means asserted
  input wire logic activity_or_select_pin_in,
  output logic activity_or_select_pin_out,
  output logic activity_or_select_pin_oe,
  // Unit number strap, high for unit 1
  input wire logic unit_strap,
  // Primary interrupt pin
  output logic irq_out,
  output logic irq_oe,
  // Diagnostic or second interrupt pin
  output logic diag_or_second_irq_pin_out,
  output logic diag_or_second_irq_pin_oe,
  // Command issue to the media engine
  output logic cmd_issue,
  output logic [7:0] cmd_code,
  output logic [2:0] cmd_tag,
  output logic [39:0] cmd_params,
  output logic queue_abort,
  input wire logic cmd_done,
  // Service events from the media engine
  input wire logic evt_valid,
  input wire logic evt_status,
  input wire logic evt_err,
  input wire logic [2:0] evt_tag,
  output logic evt_ready,
  // Data words for the data register
  input wire logic [15:0] data_word,
  output logic data_pop,
  // Context lookup and mode view
  input wire logic [2:0] ctx_tag,
  output logic [47:0] ctx_word,
  output logic [7:0] ctx_valid,
  output logic overlap_mode
);
  // Command classification
  function automatic ovq_kind_t kind_of(input logic [7:0] c);
    if (c == `OVQ_CMD_PIO_RD || c == `OVQ_CMD_PIO_WR)
      return OVQ_K_PIO;
    else if (c == `OVQ_CMD_DMA_RD || c == `OVQ_CMD_DMA_WR)
      return OVQ_K_DMA;
    else if (c == `OVQ_CMD_SETF)
      return OVQ_K_SETF;
    else
      return OVQ_K_NONDATA;
  endfunction : kind_of

  logic [1:0] sel_sync_q, strap_sync_q, strap_cnt_q;
  logic unit_q, strap_done_q;
  logic ovl_q, unit_select_line_q, nien_q;
  logic [7:0] feat_q, scnt_q, snum_q, cyll_q, cylh_q, head_q, err_q;
  logic drq_q, cc_q, int_q, raise_q, err_st_q;
  logic [2:0] svc_tag_q;
  logic [8:0] word_cnt_q;
  ovq_state_t state_q, state_d;
  ovq_kind_t qkind_q;
  logic [15:0] rdata_q;
  logic issue_q, qabort_q, pop_q;
  logic [7:0] code_q;
  logic [2:0] tag_q;
  logic [39:0] params_q;

  // Pin synchronisers; only the second stage is read
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sel_sync_q <= 2'b11;
      strap_sync_q <= 2'b00;
    end
    else
    begin
      sel_sync_q <= {sel_sync_q[0], activity_or_select_pin_in};
      strap_sync_q <= {strap_sync_q[0], unit_strap};
    end
  end

  // Strap caught once the synchroniser has settled after reset
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strap_cnt_q <= 2'd0;
      strap_done_q <= 1'b0;
      unit_q <= 1'b0;
    end
    else if (!strap_done_q)
    begin
      strap_cnt_q <= strap_cnt_q + 2'd1;
      if (strap_cnt_q == `OVQ_STRAP_WAIT)
      begin
        unit_q <= strap_sync_q[1];
        strap_done_q <= 1'b1;
      end
    end
  end

  // Selection: with the select line enabled, low picks unit 0 and high unit 1; else head unit bit
  wire sel_unit0 = ~sel_sync_q[1]; // [RULE_27]
  wire selected = (ovl_q & unit_select_line_q) ? (unit_q ? ~sel_unit0 : sel_unit0)
                                   : (head_q[`OVQ_HEAD_UNIT] == unit_q);
  wire head_pass = ~(ovl_q & unit_select_line_q) & (reg_addr == `OVQ_A_HEAD);
  wire acc_ok = selected | (head_pass & reg_wr); // [RULE_28]
  wire busy = (state_q != OVQ_S_IDLE);
  wire cb_addr = (reg_addr >= `OVQ_A_ERRFEAT) & (reg_addr <= `OVQ_A_STATCMD);
  // Command block locked while busy and when not selected, except head writes while the select line is off
  wire cb_wr = reg_wr & acc_ok & cb_addr & ~busy; // [RULE_06] [RULE_01]
  wire ctl_wr = reg_wr & selected & (reg_addr == `OVQ_A_ALTCTL);
  wire cmd_wr = cb_wr & (reg_addr == `OVQ_A_STATCMD);
  wire stat_rd = reg_rd & selected & (reg_addr == `OVQ_A_STATCMD);
  wire data_rd = reg_rd & selected & (reg_addr == `OVQ_A_DATA) & drq_q;

  // Command screening against mode, depth and queue contents
  wire [7:0] cmd_in = reg_wdata[7:0];
  wire ovq_kind_t kind = kind_of(cmd_in);
  wire is_data = (kind == OVQ_K_PIO) | (kind == OVQ_K_DMA);
  wire queued = ovl_q & feat_q[`OVQ_FEAT_OVL] & is_data; // [RULE_25]
  wire [2:0] tag_in = feat_q[2:0];
  wire tag_bad = queued & ({1'b0, tag_in} > `OVQ_QDEPTH_FIELD); // [RULE_12]
  wire q_exists = (ctx_valid != 8'h00);
  wire mix_bad = q_exists & (~queued | (kind != qkind_q)); // [RULE_15]
  wire cmd_abort = cmd_wr & (tag_bad | mix_bad);
  wire cmd_go = cmd_wr & ~tag_bad & ~mix_bad;
  wire save_go = cmd_go & (queued | (kind == OVQ_K_SETF));

  // Busy sequencing: save is a single busy cycle, execute waits for done
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      OVQ_S_IDLE:
        if (cmd_go)
          state_d = save_go ? OVQ_S_SAVE : OVQ_S_EXEC; // [RULE_01] [RULE_02]
      OVQ_S_SAVE:
        state_d = OVQ_S_IDLE; // [RULE_01] [RULE_03]
      OVQ_S_EXEC:
        if (cmd_done)
          state_d = OVQ_S_IDLE; // [RULE_02]
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      state_q <= OVQ_S_IDLE;
    else
      state_q <= state_d;
  end

  // Command block registers
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      feat_q <= 8'h00;
      scnt_q <= 8'h00;
      snum_q <= 8'h00;
      cyll_q <= 8'h00;
      cylh_q <= 8'h00;
      head_q <= `OVQ_HEAD_RST;
    end
    else if (cb_wr)
    begin
      if (reg_addr == `OVQ_A_ERRFEAT)
        feat_q <= reg_wdata[7:0];
      if (reg_addr == `OVQ_A_SCNT)
        scnt_q <= reg_wdata[7:0];
      if (reg_addr == `OVQ_A_SNUM)
        snum_q <= reg_wdata[7:0];
      if (reg_addr == `OVQ_A_CYLL)
        cyll_q <= reg_wdata[7:0];
      if (reg_addr == `OVQ_A_CYLH)
        cylh_q <= reg_wdata[7:0];
      if (reg_addr == `OVQ_A_HEAD)
        head_q <= reg_wdata[7:0];
    end
  end

  // Mode flags; legacy after reset, set-features switches overlap
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ovl_q <= 1'b0;
      unit_select_line_q <= 1'b0;
      nien_q <= 1'b0;
    end
    else
    begin
      if (ctl_wr)
        nien_q <= reg_wdata[`OVQ_CTL_NIEN];
      if (cmd_go && kind == OVQ_K_SETF)
      begin
        if (feat_q == `OVQ_SF_OVL_NOSEL || feat_q == `OVQ_SF_OVL_SEL) // [RULE_16]
        begin
          ovl_q <= 1'b1;
          unit_select_line_q <= (feat_q == `OVQ_SF_OVL_SEL);
        end
        else if (feat_q == `OVQ_SF_OVL_OFF)
        begin
          ovl_q <= 1'b0;
          unit_select_line_q <= 1'b0;
        end
      end
    end
  end

  // Saved contexts, one per outstanding queued tag
  wire ctx_clr = stat_rd & cc_q; // [RULE_23]
  ovq_ctx_store u_ctx (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .wr_en(save_go & queued), // [RULE_29]
    .wr_tag(tag_in),
    .wr_word({cmd_in, feat_q, scnt_q, snum_q, cyll_q, cylh_q}),
    .clr_en(ctx_clr),
    .clr_tag(svc_tag_q),
    .clr_all(cmd_abort & mix_bad), // [RULE_15]
    .rd_tag(ctx_tag),
    .rd_word(ctx_word),
    .valid_mask(ctx_valid)
  );

  // Engine issue, queue kind and error register
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      issue_q <= 1'b0;
      qabort_q <= 1'b0;
      code_q <= 8'h00;
      tag_q <= 3'h0;
      params_q <= 40'h0;
      qkind_q <= OVQ_K_NONDATA;
      err_q <= 8'h00;
    end
    else
    begin
      issue_q <= cmd_go & (kind != OVQ_K_SETF);
      qabort_q <= cmd_abort & mix_bad;
      if (cmd_go)
      begin
        code_q <= cmd_in;
        tag_q <= tag_in;
        params_q <= {feat_q, scnt_q, snum_q, cyll_q, cylh_q};
        err_q <= 8'h00;
      end
      if (save_go & queued)
        qkind_q <= kind;
      if (cmd_abort)
        err_q <= 8'h01 << `OVQ_ERR_ABRT;
    end
  end

  // Service flags; a set wins over a clear in the same cycle, except the error bit, which a taken event loads even over an abort
  wire svc_busy = drq_q | cc_q | raise_q | int_q;
  wire take = evt_valid & ~svc_busy;
  wire last_word = data_rd & (word_cnt_q == `OVQ_BLOCK_WORDS - 9'd1);
  wire cc_set = (take & evt_status) | cmd_abort;
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      drq_q <= 1'b0;
      cc_q <= 1'b0;
      raise_q <= 1'b0;
      int_q <= 1'b0;
      err_st_q <= 1'b0;
      svc_tag_q <= 3'h0;
    end
    else
    begin
      drq_q <= (take & ~evt_status) | (drq_q & ~last_word); // [RULE_19] [RULE_21]
      cc_q <= cc_set | (cc_q & ~stat_rd); // [RULE_22] [RULE_26] [RULE_23]
      raise_q <= take | cmd_abort; // [RULE_19] [RULE_22]
      int_q <= raise_q | (int_q & ~stat_rd); // [RULE_20]
      if (take)
      begin
        svc_tag_q <= evt_tag;
        err_st_q <= evt_status & evt_err;
      end
      else if (cmd_abort)
        err_st_q <= 1'b1;
      else if (cmd_go)
        err_st_q <= 1'b0;
    end
  end

  // Data word counter over one request block
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      word_cnt_q <= 9'd0;
    else if (last_word || take)
      word_cnt_q <= 9'd0;
    else if (data_rd)
      word_cnt_q <= word_cnt_q + 9'd1;
  end

  // Readback views
  wire queuing = ovl_q & (`OVQ_QDEPTH_FIELD != 4'h0);
  wire [7:0] head_view = queuing ? {svc_tag_q[2], head_q[6], svc_tag_q[1:0], head_q[3:0]}
                                 : head_q; // [RULE_14]
  wire [7:0] stat_view = {busy, 1'b1, 1'b0, 1'b1, drq_q, 1'b0, cc_q & ovl_q, err_st_q};
  wire [15:0] id71 = (16'h0001 << `OVQ_ID_OVL) // [RULE_10]
                   | ({12'h000, `OVQ_QDEPTH_FIELD} << `OVQ_ID_QD_LSB); // [RULE_11] [RULE_30]
  wire [7:0] byte_mux =
    (reg_addr == `OVQ_A_ERRFEAT) ? err_q :
    (reg_addr == `OVQ_A_SCNT) ? scnt_q :
    (reg_addr == `OVQ_A_SNUM) ? snum_q :
    (reg_addr == `OVQ_A_CYLL) ? cyll_q :
    (reg_addr == `OVQ_A_CYLH) ? cylh_q :
    (reg_addr == `OVQ_A_HEAD) ? head_view :
    ((reg_addr == `OVQ_A_STATCMD) || (reg_addr == `OVQ_A_ALTCTL)) ? stat_view : 8'h00;
  wire [15:0] rd_mux = (reg_addr == `OVQ_A_DATA) ? (drq_q ? data_word : 16'h0000) :
                       (reg_addr == `OVQ_A_ID71) ? id71 : {8'h00, byte_mux};

  // Read data stands only in the cycle after the strobe; unselected reads return zero
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata_q <= 16'h0000;
      pop_q <= 1'b0;
    end
    else
    begin
      rdata_q <= (reg_rd & selected) ? rd_mux : 16'h0000;
      pop_q <= data_rd;
    end
  end

  // Interrupt routing by unit number in overlap, by selection in legacy
  wire irq_lvl = int_q & ~nien_q;
  assign irq_oe = ovl_q ? ~unit_q : selected; // [RULE_07]
  assign irq_out = irq_oe & irq_lvl;
  assign diag_or_second_irq_pin_oe = ovl_q & unit_q; // [RULE_07]
  assign diag_or_second_irq_pin_out = ovl_q & unit_q & irq_lvl;
  // Pin is an input while the select line is enabled, activity output otherwise
  assign activity_or_select_pin_oe = ~(ovl_q & unit_select_line_q) & (busy | drq_q);
  assign activity_or_select_pin_out = 1'b0;

  assign evt_ready = ~svc_busy;
  assign reg_rdata = rdata_q;
  assign cmd_issue = issue_q;
  assign cmd_code = code_q;
  assign cmd_tag = tag_q;
  assign cmd_params = params_q;
  assign queue_abort = qabort_q;
  assign data_pop = pop_q;
  assign overlap_mode = ovl_q;
endmodule : ovq_ctrl

// ### ovq_ctrl_asserts.sv
// Port-level checker for the overlap and queue control block
module ovq_ctrl_asserts
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Host register port
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Pins
  input wire logic activity_or_select_pin_out,
  input wire logic irq_oe,
  input wire logic diag_or_second_irq_pin_out,
  input wire logic diag_or_second_irq_pin_oe,
  // Engine side
  input wire logic cmd_issue,
  input wire logic queue_abort,
  input wire logic evt_ready,
  input wire logic data_pop,
  input wire logic overlap_mode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // An answered status read; unselected reads come back all zero
  sequence stat_read_s;
    reg_rd && reg_addr == 4'h7 ##1 reg_rdata[6];
  endsequence
  // Alternate status read while the second line is up
  sequence alt_read_s;
    reg_rd && reg_addr == 4'h8 && diag_or_second_irq_pin_out;
  endsequence
  issue_cause_a: assert property (cmd_issue |->
    ($past(reg_wr) && $past(reg_addr) == 4'h7))
    else $error("command issued without a command write");
  abort_cause_a: assert property (queue_abort |->
    ($past(reg_wr) && $past(reg_addr) == 4'h7))
    else $error("queue abort without a command write");
  abort_excl_a: assert property (queue_abort |-> !cmd_issue)
    else $error("aborted command was still issued");
  second_line_a: assert property (diag_or_second_irq_pin_oe |-> overlap_mode)
    else $error("second interrupt line driven outside overlap mode");
  one_line_a: assert property (overlap_mode |-> !(irq_oe && diag_or_second_irq_pin_oe))
    else $error("both interrupt lines driven in overlap mode");
  pop_cause_a: assert property (data_pop |->
    ($past(reg_rd) && $past(reg_addr) == 4'h0))
    else $error("data word popped without a data read");
  hold_off_a: assert property (diag_or_second_irq_pin_out |-> !evt_ready)
    else $error("new service taken while interrupt pending");
  stat_drop_a: assert property (stat_read_s |-> !diag_or_second_irq_pin_out)
    else $error("interrupt still up after status read");
  alt_keep_a: assert property (alt_read_s |=> diag_or_second_irq_pin_out)
    else $error("alternate status read dropped the interrupt");
  pin_release_a: assert property (activity_or_select_pin_out == 1'b0)
    else $error("select pin driven high");
endmodule : ovq_ctrl_asserts

bind ovq_ctrl ovq_ctrl_asserts ovq_ctrl_asserts_inst (.ref_clk, .reset_n, .reg_addr, .reg_wr,
  .reg_rd, .reg_rdata, .activity_or_select_pin_out, .irq_oe, .diag_or_second_irq_pin_out,
  .diag_or_second_irq_pin_oe, .cmd_issue, .queue_abort, .evt_ready, .data_pop, .overlap_mode);

// ### ovq_engine_model.sv
// Media engine stand-in: finishes non-data commands and feeds data words
module ovq_engine_model
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Command side
  input wire logic cmd_issue,
  input wire logic [7:0] cmd_code,
  output logic cmd_done,
  // Data side
  input wire logic data_pop,
  output logic [15:0] data_word
);
  logic [4:0] wait_q;
  logic [15:0] idx_q;
  logic run_q;
  // Words follow a counter so the bench can predict each one
  assign data_word = 16'ha500 + idx_q;
  // Non-data commands take a slow fixed time, keeping busy up meanwhile
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wait_q <= 5'h00;
      run_q <= 1'b0;
      cmd_done <= 1'b0;
      idx_q <= 16'h0000;
    end
    else
    begin
      cmd_done <= run_q && wait_q == 5'h14;
      if (cmd_issue && !(cmd_code inside {8'h20, 8'h30, 8'hc8, 8'hca}))
        run_q <= 1'b1;
      else if (cmd_done)
        run_q <= 1'b0;
      wait_q <= run_q ? wait_q + 5'h01 : 5'h00;
      if (data_pop)
        idx_q <= idx_q + 16'h0001;
    end
  end
endmodule : ovq_engine_model

// ### ovq_ctrl_tb.sv
// Self-checking bench for the overlap and queue control block
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module ovq_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic host_sel = 1'b1;
  logic strap = 1'b1;
  logic irq_pin;
  logic evt_valid = 1'b0;
  logic evt_status = 1'b0;
  logic evt_err = 1'b0;
  logic [2:0] evt_tag = 3'h0;
  logic [2:0] ctx_tag = 3'h0;
  logic act_oe, irq_oe, diag_out, cmd_issue, queue_abort, cmd_done, evt_ready, data_pop;
  logic overlap_mode;
  logic [7:0] cmd_code, ctx_valid;
  logic [2:0] cmd_tag;
  logic [15:0] data_word, v;
  logic [47:0] ctx_word;
  logic abort_seen = 1'b0;
  logic [7:0] issue_cnt = 8'h00;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [7:0] sf [4] = '{8'hdd, 8'hde, 8'hdf, 8'hdd};
  logic om [4] = '{1'b1, 1'b1, 1'b0, 1'b1};

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  ovq_ctrl ovq_ctrl_inst (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .activity_or_select_pin_in(host_sel & ~act_oe), .activity_or_select_pin_out(),
    .activity_or_select_pin_oe(act_oe), .unit_strap(strap), .irq_out(irq_pin), .irq_oe,
    .diag_or_second_irq_pin_out(diag_out), .diag_or_second_irq_pin_oe(), .cmd_issue,
    .cmd_code, .cmd_tag, .cmd_params(), .queue_abort, .cmd_done, .evt_valid, .evt_status,
    .evt_err, .evt_tag, .evt_ready, .data_word, .data_pop, .ctx_tag, .ctx_word, .ctx_valid,
    .overlap_mode);
  ovq_engine_model ovq_engine_model_inst (.ref_clk, .reset_n, .cmd_issue, .cmd_code,
    .cmd_done, .data_pop, .data_word);

  // Pulse tallies and hang guard; a hang counts as a failure
  always @(posedge ref_clk)
  begin
    cycles++;
    if (queue_abort)
      abort_seen <= 1'b1;
    if (cmd_issue)
      issue_cnt <= issue_cnt + 8'h01;
    if (cycles == 5000)
    begin
      mismatches++;
      finish_test();
    end
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= {8'h00, d};
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd
  task automatic chk_rd(input string nm, input logic [3:0] a, input logic [15:0] e);
    rd(a);
    `CHK(nm, e, v)
  endtask : chk_rd
  // Event is held for one edge, then until the block shows ready, for at most 100 more cycles
  task automatic post_evt(input logic st, input logic [2:0] t);
    @(posedge ref_clk);
    evt_valid <= 1'b1;
    evt_status <= st;
    evt_tag <= t;
    @(posedge ref_clk);
    for (int i = 0; i < 100 && !evt_ready; i++) @(posedge ref_clk);
    evt_valid <= 1'b0;
  endtask : post_evt
  task automatic wait_irq;
    for (int i = 0; i < 50 && !diag_out; i++) @(posedge ref_clk);
    #1;
    `CHK("second irq", 1'b1, diag_out)
  endtask : wait_irq
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  // Main sequence
  initial
  begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    wr(4'h6, 8'h10);
    chk_rd("ident", 4'h9, 16'h9800);
    chk_rd("idle status", 4'h7, 16'h0050);
    for (int k = 0; k < 4; k++)
    begin
      wr(4'h1, sf[k]);
      wr(4'h7, 8'hef);
      repeat (3) @(posedge ref_clk);
      `CHK("overlap mode", om[k], overlap_mode)
      if (k == 1)
      begin
        host_sel <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk_rd("unselected", 4'h7, 16'h0000);
        host_sel <= 1'b1;
        repeat (4) @(posedge ref_clk);
      end
    end
    $display("test modes done");
    wr(4'h1, 8'h80);
    wr(4'h7, 8'h20);
    chk_rd("busy cleared", 4'h7, 16'h0050);
    wr(4'h1, 8'h82);
    wr(4'h7, 8'h20);
    #1;
    `CHK("valid tags", 8'h05, ctx_valid)
    `CHK("issued tag", 3'h2, cmd_tag)
    `CHK("saved ctx", 16'h2080, ctx_word[47:32])
    post_evt(1'b0, 3'h2);
    wait_irq();
    `CHK("primary oe", 1'b0, irq_oe)
    rd(4'h6);
    `CHK("head tag", 3'b010, {v[7], v[5], v[4]})
    chk_rd("alt drq", 4'h8, 16'h0058);
    `CHK("irq kept", 1'b1, diag_out)
    chk_rd("status drq", 4'h7, 16'h0058);
    `CHK("irq dropped", 1'b0, diag_out)
    for (int i = 0; i < 256; i++)
      chk_rd("data", 4'h0, 16'ha500 + i[15:0]);
    chk_rd("drq off", 4'h7, 16'h0050);
    post_evt(1'b1, 3'h2);
    wait_irq();
    chk_rd("alt cc", 4'h8, 16'h0052);
    chk_rd("status cc", 4'h7, 16'h0052);
    chk_rd("cc cleared", 4'h8, 16'h0050);
    `CHK("tag released", 8'h01, ctx_valid)
    $display("test service done");
    wr(4'h1, 8'h84);
    wr(4'h7, 8'h20);
    wait_irq();
    chk_rd("abort err", 4'h1, 16'h0004);
    chk_rd("abort status", 4'h7, 16'h0053);
    wr(4'h1, 8'h83);
    wr(4'h7, 8'hc8);
    wait_irq();
    `CHK("queue abort", 1'b1, abort_seen)
    `CHK("queue empty", 8'h00, ctx_valid)
    chk_rd("kill status", 4'h7, 16'h0053);
    $display("test aborts done");
    wr(4'h7, 8'h10);
    chk_rd("nondata busy", 4'h7, 16'h00d0);
    repeat (40) @(posedge ref_clk);
    rd(4'h7);
    `CHK("nondata end", 1'b0, v[7])
    `CHK("issue count", 8'h03, issue_cnt)
    $display("test nondata done");
    // Second reset as unit 0 of a fully overlapped pair, select pin low
    strap <= 1'b0;
    host_sel <= 1'b0;
    reset_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    `CHK("legacy oe", 1'b1, irq_oe)
    wr(4'h1, 8'hde);
    wr(4'h7, 8'hef);
    wr(4'h8, 8'h02);
    post_evt(1'b1, 3'h0);
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("masked irq", 1'b0, irq_pin)
    wr(4'h8, 8'h00);
    #1;
    `CHK("unit0 irq", 2'b10, {irq_pin, diag_out})
    chk_rd("unit0 status", 4'h7, 16'h0052);
    `CHK("unit0 drop", 1'b0, irq_pin)
    $display("test unit 0 done");
    finish_test();
  end
endmodule : ovq_ctrl_tb
